// [shared/ddrci_defines.svh]
`ifndef DDRCI_DEFINES_SVH
`define DDRCI_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DDRCI_ADDR_W 12
`define DDRCI_DQ_W 8
`define DDRCI_BANKS 4
`define DDRCI_MEM_DEPTH 64

// ----------------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------------
`define DDRCI_REG_CTRL 8'h00
`define DDRCI_REG_STATUS 8'h04
`define DDRCI_REG_MODE 8'h08
`define DDRCI_REG_EXT_MODE 8'h0c
`define DDRCI_REG_REFRESH 8'h10
`define DDRCI_CTRL_RESET 8'h00
`define DDRCI_CTRL_DLL_BYPASS 0

// ----------------------------------------------------------------
// mode opcode fields and codes
// ----------------------------------------------------------------
`define DDRCI_MODE_BL_MSB 2
`define DDRCI_MODE_BL_LSB 0
`define DDRCI_MODE_BT 3
`define DDRCI_MODE_CL_MSB 6
`define DDRCI_MODE_CL_LSB 4
`define DDRCI_MODE_DLL_RST 8
`define DDRCI_PRECHARGE_ALL_BIT 10
`define DDRCI_BL_CODE_2 3'h1
`define DDRCI_BL_CODE_4 3'h2
`define DDRCI_BL_CODE_8 3'h3
`define DDRCI_CL_CODE_25 3'h6

// ----------------------------------------------------------------
// timing counts, in link clock half periods or link cycles
// ----------------------------------------------------------------
`define DDRCI_LAT_EDGES_CL2 4'h4
`define DDRCI_LAT_EDGES_CL25 4'h5
`define DDRCI_DLL_LOCK_CYCLES 8'hc8

`endif

// [shared/ddrci_pkg.sv]
package ddrci_pkg;
`include "ddrci_defines.svh"

  typedef enum logic [1:0] {
    PW_ACTIVE = 2'h0,
    PW_PRE_PD = 2'h1,
    PW_ACT_PD = 2'h3,
    PW_SELF_REF = 2'h2
  } ddrci_power_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_MODE = 3'h6,
    CMD_BST = 3'h7
  } ddrci_cmd_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic [`DDRCI_ADDR_W-1:0] addr;
  } ddrci_cmd_pins_t;

  typedef struct packed {
    logic strobe;
    logic [`DDRCI_DQ_W-1:0] dq;
    logic write_byte_mask;
  } ddrci_data_in_t;

  typedef struct packed {
    logic [`DDRCI_DQ_W-1:0] dq;
    logic strobe;
    logic dq_oe_n;
    logic strobe_oe_n;
  } ddrci_data_out_t;
endpackage

// [logic/ddrci_core.sv]
// Contract
// - data moves on both clock edges
// - command inputs sampled on true clock rise
// - chip select high masks every command
// - command decoded from strobes plus select
// - masked write beats never reach array
// - mask sampled on both strobe edges
// - mask has no effect on reads
// - strobe edge aligned out, centred in
// - read outputs aligned to clock edges
// - bank select picks the target bank
// - four banks may be open together
// - address carries row or column plus flag
// - precharge all bit closes every bank
// - mode load picks base or extended register
// - clock enable gates buffers and drivers
// - clock enable low enters three power states
// - drivers turn off without waiting
// - power-down ignores command inputs
// - read latency two or two and half
// - burst length and ordering programmable
// - base opcode field placement
`include "ddrci_defines.svh"

module ddrci_core
  (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic wb_cyc, // wishbone cycle
  input wire logic wb_stb, // wishbone strobe
  input wire logic wb_we, // wishbone write
  input wire logic [7:0] wb_adr, // wishbone byte address
  input wire logic [3:0] wb_sel, // wishbone byte select
  input wire logic [31:0] wb_dat_w, // wishbone write data
  output logic [31:0] wb_dat_r, // wishbone read data
  output logic wb_ack, // wishbone acknowledge
  input wire logic diff_clock_pair_p, // link clock, true
  input wire logic diff_clock_pair_n, // link clock, complement
  input wire ddrci_pkg::ddrci_cmd_pins_t cmd_pins, // command pins
  input wire ddrci_pkg::ddrci_data_in_t data_in, // data pins, received level
  output ddrci_pkg::ddrci_data_out_t data_out // data pins, drive side
  );

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic ddrci_pkg::ddrci_cmd_t decode_cmd(input ddrci_pkg::ddrci_cmd_pins_t p);
    case ({p.ras_n, p.cas_n, p.we_n})
      3'h3: decode_cmd = ddrci_pkg::CMD_ACT;
      3'h5: decode_cmd = ddrci_pkg::CMD_READ;
      3'h4: decode_cmd = ddrci_pkg::CMD_WRITE;
      3'h2: decode_cmd = ddrci_pkg::CMD_PRE;
      3'h1: decode_cmd = ddrci_pkg::CMD_REF;
      3'h0: decode_cmd = ddrci_pkg::CMD_MODE;
      3'h6: decode_cmd = ddrci_pkg::CMD_BST;
      default: decode_cmd = ddrci_pkg::CMD_NOP;
    endcase
  endfunction

  // reserved length codes fall back to the shortest burst
  function automatic logic [3:0] burst_beats(input logic [`DDRCI_ADDR_W-1:0] m);
    case (m[`DDRCI_MODE_BL_MSB:`DDRCI_MODE_BL_LSB])
      `DDRCI_BL_CODE_4: burst_beats = 4'h4;
      `DDRCI_BL_CODE_8: burst_beats = 4'h8;
      default: burst_beats = 4'h2;
    endcase
  endfunction

  function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] idx,
                                           input logic [3:0] beats, input logic interleave);
    logic [2:0] wrap;
    logic [2:0] seq;
    wrap = 3'(beats - 4'h1);
    seq = start + idx;
    if (interleave)
      burst_col = (start & ~wrap) | ((start ^ idx) & wrap);
    else
      burst_col = (start & ~wrap) | (seq & wrap);
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers and link edge detection
  // ----------------------------------------------------------------
  ddrci_pkg::ddrci_cmd_pins_t cmd_m_q, cmd_s_q;
  ddrci_pkg::ddrci_data_in_t dat_m_q, dat_s_q;
  logic [1:0] ck_m_q, ck_s_q;
  logic link_hi_q, strobe_prev_q;
  logic link_hi, link_rise, link_edge, strobe_edge;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmd_m_q <= '0;
      cmd_s_q <= '0;
      dat_m_q <= '0;
      dat_s_q <= '0;
      ck_m_q <= 2'h0;
      ck_s_q <= 2'h0;
      link_hi_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      cmd_m_q <= cmd_pins;
      cmd_s_q <= cmd_m_q;
      dat_m_q <= data_in;
      dat_s_q <= dat_m_q;
      ck_m_q <= {diff_clock_pair_n, diff_clock_pair_p};
      ck_s_q <= ck_m_q;
      link_hi_q <= link_hi;
      strobe_prev_q <= dat_s_q.strobe;
    end
  end

  // true clock rising coincides with complement falling
  assign link_hi = ck_s_q[0] & ~ck_s_q[1];
  assign link_rise = link_hi & ~link_hi_q;
  assign link_edge = link_hi ^ link_hi_q;
  assign strobe_edge = dat_s_q.strobe ^ strobe_prev_q;

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  ddrci_pkg::ddrci_power_t power_q;
  ddrci_pkg::ddrci_cmd_t cmd;
  logic cmd_take;
  logic [1:0] ba;
  logic [`DDRCI_ADDR_W-1:0] addr;

  assign cmd = decode_cmd(cmd_s_q);
  assign ba = cmd_s_q.bank_select;
  assign addr = cmd_s_q.addr;
  // input buffers are off outside the active state
  assign cmd_take = link_rise & ~cmd_s_q.cs_n & cmd_s_q.cke
                    & (power_q == ddrci_pkg::PW_ACTIVE);

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  logic [`DDRCI_BANKS-1:0] bank_open_q;

  always_ff @(posedge clock)
  begin
    if (rst)
      power_q <= ddrci_pkg::PW_ACTIVE;
    else if (link_rise)
    begin
      case (power_q)
        ddrci_pkg::PW_ACTIVE:
        begin
          if (!cmd_s_q.cke)
          begin
            if (|bank_open_q)
              power_q <= ddrci_pkg::PW_ACT_PD;
            else if (!cmd_s_q.cs_n && cmd == ddrci_pkg::CMD_REF)
              power_q <= ddrci_pkg::PW_SELF_REF;
            else
              power_q <= ddrci_pkg::PW_PRE_PD;
          end
        end
        default:
        begin
          if (cmd_s_q.cke)
            power_q <= ddrci_pkg::PW_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode registers and dll lock
  // ----------------------------------------------------------------
  logic [`DDRCI_ADDR_W-1:0] mode_q, ext_mode_q;
  logic [7:0] dll_cnt_q;
  logic dll_locked;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_q <= '0;
      ext_mode_q <= '0;
    end
    else if (cmd_take && cmd == ddrci_pkg::CMD_MODE)
    begin
      if (ba[0])
        ext_mode_q <= addr;
      else
        mode_q <= addr;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      dll_cnt_q <= 8'h00;
    else if (cmd_take && cmd == ddrci_pkg::CMD_MODE && !ba[0] && addr[`DDRCI_MODE_DLL_RST])
      dll_cnt_q <= `DDRCI_DLL_LOCK_CYCLES;
    else if (link_rise && dll_cnt_q != 8'h00)
      dll_cnt_q <= dll_cnt_q - 8'h01;
  end

  assign dll_locked = (dll_cnt_q == 8'h00);

  // ----------------------------------------------------------------
  // read engine, counted in link half periods
  // ----------------------------------------------------------------
  logic [`DDRCI_DQ_W-1:0] mem_q [`DDRCI_MEM_DEPTH];
  logic rd_busy_q, rd_ap_q, rd_strobe_q, rd_oe_n_q;
  logic [3:0] rd_cnt_q, rd_lat_q, rd_bl_q, rd_next, rd_stop;
  logic [1:0] rd_bank_q;
  logic [3:0] rd_col_q;
  logic [2:0] rd_idx;
  logic [`DDRCI_DQ_W-1:0] rd_dq_q, rd_word;
  logic rd_beat, rd_pre, rd_end, rd_int;

  assign rd_next = rd_cnt_q + 4'h1;
  assign rd_stop = rd_lat_q + rd_bl_q;
  assign rd_idx = 3'(rd_next - rd_lat_q);
  assign rd_beat = rd_busy_q & link_edge & (rd_next >= rd_lat_q) & (rd_next < rd_stop);
  assign rd_pre = rd_busy_q & link_edge & (rd_next == rd_lat_q - 4'h1);
  assign rd_end = rd_busy_q & link_edge & (rd_next == rd_stop);
  assign rd_int = mode_q[`DDRCI_MODE_BT];
  assign rd_word = mem_q[{rd_bank_q, rd_col_q[3], burst_col(rd_col_q[2:0], rd_idx, rd_bl_q, rd_int)}];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_busy_q <= 1'b0;
      rd_cnt_q <= 4'h0;
      rd_lat_q <= `DDRCI_LAT_EDGES_CL2;
      rd_bl_q <= 4'h2;
      rd_bank_q <= 2'h0;
      rd_col_q <= 4'h0;
      rd_ap_q <= 1'b0;
    end
    else if (cmd_take && cmd == ddrci_pkg::CMD_READ)
    begin
      rd_busy_q <= 1'b1; // a new read cuts the old burst short
      rd_cnt_q <= 4'h0;
      rd_lat_q <= (mode_q[`DDRCI_MODE_CL_MSB:`DDRCI_MODE_CL_LSB] == `DDRCI_CL_CODE_25) ?
                  `DDRCI_LAT_EDGES_CL25 : `DDRCI_LAT_EDGES_CL2;
      rd_bl_q <= burst_beats(mode_q);
      rd_bank_q <= ba;
      rd_col_q <= addr[3:0];
      rd_ap_q <= addr[`DDRCI_PRECHARGE_ALL_BIT];
    end
    else if (cmd_take && (cmd == ddrci_pkg::CMD_WRITE || cmd == ddrci_pkg::CMD_BST))
      rd_busy_q <= 1'b0;
    else if (rd_end)
      rd_busy_q <= 1'b0;
    else if (rd_busy_q && link_edge)
      rd_cnt_q <= rd_next;
  end

  // outputs move on the detected clock edges, standing in for the lock loop
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_dq_q <= '0;
      rd_strobe_q <= 1'b0;
      rd_oe_n_q <= 1'b1;
    end
    else if (rd_beat)
    begin
      rd_dq_q <= rd_word;
      rd_strobe_q <= ~rd_idx[0];
      rd_oe_n_q <= 1'b0;
    end
    else if (rd_pre)
    begin
      rd_strobe_q <= 1'b0;
      rd_oe_n_q <= 1'b0;
    end
    else if (rd_end || !rd_busy_q)
    begin
      rd_strobe_q <= 1'b0;
      rd_oe_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // write engine, paced by the controller's strobe
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic wr_busy_q, wr_ap_q, wr_beat, wr_end;
  logic [3:0] wr_left_q, wr_bl_q;
  logic [2:0] wr_idx_q;
  logic [1:0] wr_bank_q;
  logic [3:0] wr_col_q;
  logic [5:0] wr_index;

  assign wr_beat = wr_busy_q & strobe_edge & cmd_s_q.cke;
  assign wr_end = wr_beat & (wr_left_q == 4'h1);
  assign wr_index = {wr_bank_q, wr_col_q[3],
                     burst_col(wr_col_q[2:0], wr_idx_q, wr_bl_q, mode_q[`DDRCI_MODE_BT])};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_busy_q <= 1'b0;
      wr_left_q <= 4'h0;
      wr_bl_q <= 4'h2;
      wr_idx_q <= 3'h0;
      wr_bank_q <= 2'h0;
      wr_col_q <= 4'h0;
      wr_ap_q <= 1'b0;
    end
    else if (cmd_take && cmd == ddrci_pkg::CMD_WRITE)
    begin
      wr_busy_q <= 1'b1;
      wr_left_q <= burst_beats(mode_q);
      wr_bl_q <= burst_beats(mode_q);
      wr_idx_q <= 3'h0;
      wr_bank_q <= ba;
      wr_col_q <= addr[3:0];
      wr_ap_q <= addr[`DDRCI_PRECHARGE_ALL_BIT];
    end
    else if (cmd_take && cmd == ddrci_pkg::CMD_READ)
      wr_busy_q <= 1'b0;
    else if (wr_beat)
    begin
      wr_idx_q <= wr_idx_q + 3'h1;
      wr_left_q <= wr_left_q - 4'h1;
      if (wr_end)
        wr_busy_q <= 1'b0;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (wr_beat && !dat_s_q.write_byte_mask)
      mem_q[wr_index] <= dat_s_q.dq;
  end

  // ----------------------------------------------------------------
  // bank state
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      bank_open_q <= '0;
    else if (cmd_take && cmd == ddrci_pkg::CMD_ACT)
      bank_open_q[ba] <= 1'b1;
    else if (cmd_take && cmd == ddrci_pkg::CMD_PRE)
    begin
      if (addr[`DDRCI_PRECHARGE_ALL_BIT])
        bank_open_q <= '0;
      else
        bank_open_q[ba] <= 1'b0;
    end
    else if (rd_end && rd_ap_q)
      bank_open_q[rd_bank_q] <= 1'b0;
    else if (wr_end && wr_ap_q)
      bank_open_q[wr_bank_q] <= 1'b0;
  end

  // ----------------------------------------------------------------
  // pin drive; drivers drop as soon as clock enable is seen low
  // ----------------------------------------------------------------
  logic drv_off;

  // reads before the loop locks leave the bus undriven unless the ctrl bypass bit is set
  assign drv_off = rd_oe_n_q | ~cmd_s_q.cke
                   | ~(dll_locked | ctrl_q[`DDRCI_CTRL_DLL_BYPASS]);
  assign data_out = '{dq: rd_dq_q, strobe: rd_strobe_q, dq_oe_n: drv_off, strobe_oe_n: drv_off};

  // ----------------------------------------------------------------
  // wishbone register slave
  // ----------------------------------------------------------------
  logic [15:0] ref_cnt_q;
  logic [31:0] wb_dat_r_q;
  logic wb_ack_q, wb_hit, wb_wr;
  logic [31:0] status;

  assign wb_hit = wb_cyc & wb_stb & ~wb_ack_q;
  assign wb_wr = wb_hit & wb_we;
  assign status = {23'h0, dll_locked, power_q, wr_busy_q, rd_busy_q, bank_open_q};

  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_q <= `DDRCI_CTRL_RESET;
    else if (wb_wr && wb_sel[0] && wb_adr == `DDRCI_REG_CTRL)
      ctrl_q <= wb_dat_w[7:0];
  end

  // refresh seen by the device; a refresh landing on a clear is kept
  always_ff @(posedge clock)
  begin
    if (rst)
      ref_cnt_q <= 16'h0000;
    else if (cmd_take && cmd == ddrci_pkg::CMD_REF)
      ref_cnt_q <= (wb_wr && wb_adr == `DDRCI_REG_REFRESH) ? 16'h0001 : ref_cnt_q + 16'h0001;
    else if (wb_wr && wb_adr == `DDRCI_REG_REFRESH)
      ref_cnt_q <= 16'h0000;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_r_q <= 32'h0;
    end
    else
    begin
      wb_ack_q <= wb_hit;
      case (wb_adr)
        `DDRCI_REG_CTRL: wb_dat_r_q <= {24'h0, ctrl_q};
        `DDRCI_REG_STATUS: wb_dat_r_q <= status;
        `DDRCI_REG_MODE: wb_dat_r_q <= {20'h0, mode_q};
        `DDRCI_REG_EXT_MODE: wb_dat_r_q <= {20'h0, ext_mode_q};
        `DDRCI_REG_REFRESH: wb_dat_r_q <= {16'h0, ref_cnt_q};
        default: wb_dat_r_q <= 32'h0;
      endcase
    end
  end

  assign wb_ack = wb_ack_q;
  assign wb_dat_r = wb_dat_r_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_take(ddrci_pkg::ddrci_cmd_t c);
    cmd_take && cmd == c;
  endsequence

  sequence s_dll_reset;
    s_take(ddrci_pkg::CMD_MODE) ##0 (!ba[0] && addr[`DDRCI_MODE_DLL_RST]);
  endsequence

  // auto precharge at burst end may close a bank while the select is high
  cs_mask_a: assert property (link_rise && cmd_s_q.cs_n && !(rd_end && rd_ap_q)
                              && !(wr_end && wr_ap_q)
                              |=> $stable(mode_q) && $stable(bank_open_q))
    else $error("command taken with chip select high");
  act_open_a: assert property (s_take(ddrci_pkg::CMD_ACT)
                               |=> bank_open_q[$past(cmd_s_q.bank_select)])
    else $error("activate did not open bank");
  pre_all_a: assert property (s_take(ddrci_pkg::CMD_PRE)
                              ##0 addr[`DDRCI_PRECHARGE_ALL_BIT] |=> bank_open_q == '0)
    else $error("precharge all left a bank open");
  pre_one_a: assert property (s_take(ddrci_pkg::CMD_PRE)
                              ##0 !addr[`DDRCI_PRECHARGE_ALL_BIT]
                              |=> !bank_open_q[$past(cmd_s_q.bank_select)]
                              && bank_open_q[$past(cmd_s_q.bank_select) ^ 2'h1]
                              == $past(bank_open_q[cmd_s_q.bank_select ^ 2'h1]))
    else $error("single precharge wrong");
  mode_load_a: assert property (s_take(ddrci_pkg::CMD_MODE) ##0 !ba[0]
                                |=> mode_q == $past(cmd_s_q.addr) && $stable(ext_mode_q))
    else $error("base mode load wrong");
  mask_write_a: assert property (wr_beat && dat_s_q.write_byte_mask
                                 |=> mem_q[$past(wr_index)] == $past(mem_q[wr_index]))
    else $error("masked beat written");
  drv_off_a: assert property (!cmd_s_q.cke |-> data_out.dq_oe_n && data_out.strobe_oe_n)
    else $error("drivers on with clock enable low");
  act_pd_a: assert property (link_rise && power_q == ddrci_pkg::PW_ACTIVE
                             && !cmd_s_q.cke && |bank_open_q
                             |=> power_q == ddrci_pkg::PW_ACT_PD)
    else $error("active power-down not entered");
  pd_ignore_a: assert property (link_rise && power_q != ddrci_pkg::PW_ACTIVE |-> !cmd_take)
    else $error("command taken in power-down");
  read_lat_a: assert property (s_take(ddrci_pkg::CMD_READ)
                               |=> rd_lat_q
                               == (($past(mode_q[6:4]) == `DDRCI_CL_CODE_25) ? 4'h5 : 4'h4))
    else $error("read latency wrong");
  read_beat_a: assert property (rd_beat
                                |=> rd_dq_q == $past(rd_word) && rd_strobe_q == !$past(rd_idx[0]))
    else $error("read beat wrong");
  dll_lock_a: assert property (s_dll_reset |=> !dll_locked [*8])
    else $error("dll locked too soon");

endmodule // ddrci_core

// [sim/ddrci_ctrl_model.sv]
module ddrci_ctrl_model (
  output logic ck_p, // link clock, true
  output logic ck_n, // link clock, complement
  input wire logic clock, // system clock, paces data beats
  output ddrci_pkg::ddrci_cmd_pins_t pins, // command pins
  output logic strobe, // strobe drive
  output logic [7:0] dq, // data drive, junk when released
  output logic mask, // write byte mask
  output logic drv_oe_n, // low while driving strobe and data
  input wire ddrci_pkg::ddrci_data_out_t dout // device drive side
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sp;
  logic [7:0] rd_q [$];

  initial
  begin
    ck_p = 1'b0;
    pins = {1'b1, 4'hf, 2'h0, 12'h000};
    strobe = 1'b0;
    dq = 8'h00;
    mask = 1'b0;
    drv_oe_n = 1'b1;
    sp = 1'b0;
    #7;
    forever #24 ck_p = ~ck_p;
  end
  assign ck_n = ~ck_p;

  // released data lines change every cycle so a stale value cannot pass
  always @(posedge clock)
  begin
    sp <= dout.strobe;
    if (drv_oe_n)
      dq <= ~dq;
    if (!dout.dq_oe_n && dout.strobe !== sp)
      rd_q.push_back(dout.dq);
  end

  // pins change mid link cycle, so they are settled at the rise
  task cmd(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a, input logic ke);
    @(negedge ck_p);
    pins <= {ke, c, ba, a};
    @(negedge ck_p);
    pins <= {ke, 4'h7, ba, a};
  endtask

  task wdata(input logic [31:0] d, input logic [3:0] m);
    integer i;
    @(posedge clock);
    drv_oe_n <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 4; i++)
    begin
      dq <= d[8*i +: 8];
      mask <= m[i];
      repeat (4) @(posedge clock);
      strobe <= ~strobe;
      repeat (4) @(posedge clock);
    end
    drv_oe_n <= 1'b1;
  endtask
endmodule // ddrci_ctrl_model

// [sim/ddr_sdram_command_data_interface_tb.sv]
module ddr_sdram_command_data_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic ck_p, ck_n, m_strobe, m_mask, m_oe_n;
  logic [7:0] m_dq;
  ddrci_pkg::ddrci_cmd_pins_t pins;
  ddrci_pkg::ddrci_data_in_t din;
  ddrci_pkg::ddrci_data_out_t dout;
  int err_count, n_compared, i;

  // wire level of the shared lines; idle strobe held low to avoid false edges
  assign din = {!dout.strobe_oe_n ? dout.strobe : (!m_oe_n && m_strobe),
                !dout.dq_oe_n ? dout.dq : m_dq, m_mask};

  ddrci_core uut (.clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .diff_clock_pair_p(ck_p), .diff_clock_pair_n(ck_n),
    .cmd_pins(pins), .data_in(din), .data_out(dout));
  ddrci_ctrl_model ctl (.ck_p(ck_p), .ck_n(ck_n), .clock(clock), .pins(pins),
    .strobe(m_strobe), .dq(m_dq), .mask(m_mask), .drv_oe_n(m_oe_n), .dout(dout));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] d);
    int n;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= wd;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50)
      chk("ack", 1, wb_ack);
    d = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task rdchk(input string what, input logic [7:0] adr, input logic [31:0] mk,
             input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    chk(what, exp, d & mk);
  endtask

  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #60000;
    err_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rdchk("status", 8'h04, 32'hff, 32'h0);
    rdchk("mode", 8'h08, 32'hfff, 32'h0);
    rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
    // bypass lets reads drive without the long lock wait
    wb(1'b1, 8'h00, 32'h1, rd);
    rdchk("ctrl", 8'h00, 32'h1, 32'h1);
    $display("test reset done");
    ctl.cmd(4'h0, 2'h0, 12'h022, 1'b1);
    repeat (2) @(negedge ck_p);
    ctl.cmd(4'h0, 2'h1, 12'h002, 1'b1);
    rdchk("mode", 8'h08, 32'hfff, 32'h022);
    rdchk("ext mode", 8'h0c, 32'hfff, 32'h002);
    repeat (2) @(negedge ck_p);
    ctl.cmd(4'h0, 2'h0, 12'h122, 1'b1);
    rdchk("dll locked", 8'h04, 32'h100, 32'h0);
    repeat (200) @(negedge ck_p);
    rdchk("dll locked", 8'h04, 32'h100, 32'h100);
    $display("test mode done");
    ctl.cmd(4'h3, 2'h1, 12'h0ab, 1'b1);
    ctl.cmd(4'h3, 2'h2, 12'h0cd, 1'b1);
    ctl.cmd(4'hb, 2'h3, 12'h0ef, 1'b1);
    rdchk("banks", 8'h04, 32'hf, 32'h6);
    ctl.cmd(4'h2, 2'h1, 12'h000, 1'b1);
    ctl.cmd(4'h3, 2'h0, 12'h001, 1'b1);
    rdchk("banks", 8'h04, 32'hf, 32'h5);
    ctl.cmd(4'h2, 2'h1, 12'h400, 1'b1);
    rdchk("banks", 8'h04, 32'hf, 32'h0);
    $display("test banks done");
    ctl.cmd(4'h3, 2'h0, 12'h010, 1'b1);
    ctl.cmd(4'h4, 2'h0, 12'h000, 1'b1);
    ctl.wdata(32'h44332211, 4'h0);
    ctl.cmd(4'h4, 2'h0, 12'h000, 1'b1);
    ctl.wdata(32'hddccbbaa, 4'h4);
    ctl.mask <= 1'b1;
    ctl.cmd(4'h5, 2'h0, 12'h000, 1'b1);
    repeat (60) @(posedge clock);
    chk("beats", 32'd4, ctl.rd_q.size());
    rd = {ctl.rd_q[3], ctl.rd_q[2], ctl.rd_q[1], ctl.rd_q[0]};
    chk("read data", 32'hdd33bbaa, rd);
    ctl.mask <= 1'b0;
    ctl.cmd(4'h2, 2'h0, 12'h400, 1'b1);
    // interleaved order and the longer latency, burst of four from column one
    ctl.cmd(4'h0, 2'h0, 12'h06a, 1'b1);
    repeat (2) @(negedge ck_p);
    ctl.cmd(4'h3, 2'h0, 12'h010, 1'b1);
    ctl.rd_q.delete();
    ctl.cmd(4'h5, 2'h0, 12'h001, 1'b1);
    repeat (60) @(posedge clock);
    chk("beats", 32'd4, ctl.rd_q.size());
    rd = {ctl.rd_q[3], ctl.rd_q[2], ctl.rd_q[1], ctl.rd_q[0]};
    chk("interleaved read", 32'h33ddaabb, rd);
    ctl.cmd(4'h2, 2'h0, 12'h400, 1'b1);
    $display("test data done");
    wb(1'b1, 8'h10, 32'h0, rd);
    for (i = 0; i < 3; i++)
      ctl.cmd(4'h1, 2'h0, 12'h000, 1'b1);
    rdchk("refreshes", 8'h10, 32'hffff, 32'h3);
    wb(1'b1, 8'h10, 32'h0, rd);
    rdchk("refreshes", 8'h10, 32'hffff, 32'h0);
    $display("test refresh done");
    ctl.cmd(4'h7, 2'h0, 12'h000, 1'b0);
    ctl.cmd(4'h3, 2'h0, 12'h000, 1'b0);
    rdchk("power", 8'h04, 32'hff, 32'h40);
    ctl.cmd(4'h7, 2'h0, 12'h000, 1'b1);
    ctl.cmd(4'h3, 2'h2, 12'h000, 1'b1);
    ctl.cmd(4'h7, 2'h0, 12'h000, 1'b0);
    rdchk("power", 8'h04, 32'hff, 32'hc4);
    chk("drivers", 32'h1, dout.dq_oe_n);
    ctl.cmd(4'h7, 2'h0, 12'h000, 1'b1);
    ctl.cmd(4'h2, 2'h0, 12'h400, 1'b1);
    ctl.cmd(4'h1, 2'h0, 12'h000, 1'b0);
    rdchk("power", 8'h04, 32'hff, 32'h80);
    ctl.cmd(4'h7, 2'h0, 12'h000, 1'b1);
    rdchk("power", 8'h04, 32'hff, 32'h00);
    $display("test power done");
    give_verdict();
  end
endmodule // ddr_sdram_command_data_interface_tb
